// ===== pkg/dpt_pkg.sv
// Package of constants shared by the dual PWM timer block.
// How it works
// - Two independent channels, each counter, comparator, flip-flop.
// - Each channel runs PWM or interval timer.
// - Shared 5-bit prescaler fed by source over two.
// - Source select 00 geared, 01 slow, 10 fast/16.
// - Taps divide source by 4, 16, 64.
// - Reset returns source select to 00.
// - Prescaler runs when run bit set, else cleared.
// - Counter steps on tap chosen by clock select.
// - Mode bit 0 PWM, 1 interval; reset 0.
// - PWM clears on overflow; interval clears on match.
// - Per-channel run/clear bit; reset stops all counters.
// - Match flags when compare equals counter.
// - Buffer enable bit, reset zero, pairs buffer.
// - Buffer loads compare on PWM overflow or interval match.
// - Shared address; write both or buffer only.
// - Reads return buffer; compare is write-only.
// - Interval match inverts flip-flop when enabled.
// - PWM flip-flop polarity selectable; period 6-8 bits.
// - Overflow wins over simultaneous match.
package dpt_pkg;
    localparam int          DPT_NCH         = 2;        // Number of channels.
    localparam int          DPT_AW          = 8;        // Register address width.
    localparam int          DPT_DW          = 8;        // Register data width.
    localparam int          DPT_PSW         = 5;        // Prescaler width.
    // Register offsets.
    localparam logic [7:0]  DPT_ADDR_CMP0   = 8'h26;    // Channel 0 compare value.
    localparam logic [7:0]  DPT_ADDR_CMP1   = 8'h27;    // Channel 1 compare value.
    localparam logic [7:0]  DPT_ADDR_RUN    = 8'h20;    // Timer run control.
    localparam logic [7:0]  DPT_ADDR_MOD0   = 8'h28;    // Channel 0 mode register.
    localparam logic [7:0]  DPT_ADDR_MOD1   = 8'h29;    // Channel 1 mode register.
    localparam logic [7:0]  DPT_ADDR_FFC    = 8'h2A;    // Flip-flop control.
    localparam logic [7:0]  DPT_ADDR_SYS    = 8'h6E;    // System clock control 0.
    // Run register fields.
    localparam int          DPT_RUN_PRE     = 7;        // Prescaler run bit.
    localparam int          DPT_RUN_CH0     = 2;        // Channel 0 count bit.
    localparam int          DPT_RUN_CH1     = 3;        // Channel 1 count bit.
    // Mode register fields.
    localparam int          DPT_MOD_CLK_LO  = 0;        // Clock select low bit.
    localparam int          DPT_MOD_PER_LO  = 2;        // Period select low bit.
    localparam int          DPT_MOD_MODE    = 5;        // Mode bit.
    localparam int          DPT_MOD_DBEN    = 6;        // Buffer enable bit.
    // Flip-flop control fields, two bits trigger plus two bits command per channel.
    localparam int          DPT_FFC_STRIDE  = 4;        // Field stride per channel.
    localparam int          DPT_FFC_TRG_LO  = 0;        // Trigger mode low bit.
    localparam int          DPT_FFC_CMD_LO  = 2;        // Direct flip-flop command low bit.
    // Source select field in system clock control 0.
    localparam int          DPT_SYS_SRC_LO  = 0;        // Source select low bit.
    // Encodings.
    localparam logic [1:0]  DPT_SRC_GEAR    = 2'h0;     // Geared fast clock.
    localparam logic [1:0]  DPT_SRC_SLOW    = 2'h1;     // Low-frequency oscillator.
    localparam logic [1:0]  DPT_SRC_FAST16  = 2'h2;     // Fast oscillator over 16.
    localparam logic [1:0]  DPT_CLK_DIV4    = 2'h1;     // Tap divide by 4.
    localparam logic [1:0]  DPT_CLK_DIV16   = 2'h2;     // Tap divide by 16.
    localparam logic [1:0]  DPT_CLK_DIV64   = 2'h3;     // Tap divide by 64.
    localparam logic [1:0]  DPT_PER_6       = 2'h1;     // Period 63.
    localparam logic [1:0]  DPT_PER_7       = 2'h2;     // Period 127.
    localparam logic [1:0]  DPT_PER_8       = 2'h3;     // Period 255.
    localparam logic [7:0]  DPT_OVF_6       = 8'h3F;    // Six-bit overflow value.
    localparam logic [7:0]  DPT_OVF_7       = 8'h7F;    // Seven-bit overflow value.
    localparam logic [7:0]  DPT_OVF_8       = 8'hFF;    // Eight-bit overflow value.
    localparam logic [1:0]  DPT_TRG_OFF     = 2'h0;     // Inversion disabled.
    localparam logic [1:0]  DPT_TRG_INV     = 2'h1;     // Invert on each event.
    localparam logic [1:0]  DPT_TRG_CLRM    = 2'h2;     // Clear on match, set on overflow.
    localparam logic [1:0]  DPT_TRG_SETM    = 2'h3;     // Set on match, clear on overflow.
    localparam logic [1:0]  DPT_CMD_NONE    = 2'h0;     // No direct action.
    localparam logic [1:0]  DPT_CMD_CLR     = 2'h1;     // Force flip-flop low.
    localparam logic [1:0]  DPT_CMD_SET     = 2'h2;     // Force flip-flop high.
    localparam logic [7:0]  DPT_ZERO8       = 8'h00;    // Byte zero.
    localparam logic [7:0]  DPT_ONE8        = 8'h01;    // Byte one.
    // Prescaler tap bit positions: bit 0 divides the half-rate source by two.
    localparam int          DPT_TAP4_BIT    = 0;        // Source over 4.
    localparam int          DPT_TAP16_BIT   = 2;        // Source over 16.
    localparam int          DPT_TAP64_BIT   = 4;        // Source over 64.
    typedef enum logic [2:0] {
        DPT_ST_IDLE = 3'b001,                           // Channel stopped.
        DPT_ST_PWM  = 3'b010,                           // Counting in PWM mode.
        DPT_ST_TMR  = 3'b100                            // Counting in interval mode.
    } dpt_state_e;
endpackage

// ===== hw/dpt_channel.sv
// One PWM or interval timer channel with counter, comparator and buffer.
`timescale 1ns/1ps
module dpt_channel
    import dpt_pkg::*;
(
    input  wire logic       mclk,           // System clock.
    input  wire logic       rst_n,          // Synchronous reset, active low.
    input  wire logic       clk_en,         // Freezes all state when low.
    input  wire logic       run,            // Count enable; low clears counter.
    input  wire logic       tick,           // Selected prescaler tap pulse.
    input  wire logic       mode_tmr,       // Interval timer mode when high.
    input  wire logic       db_en,          // Buffer enable.
    input  wire logic [1:0] period_sel,     // PWM period select.
    input  wire logic [1:0] ff_trg,         // Flip-flop trigger mode.
    input  wire logic [1:0] ff_cmd,         // Direct flip-flop command pulse value.
    input  wire logic       ff_cmd_we,      // Direct command strobe.
    input  wire logic       cmp_we,         // Compare address write strobe.
    input  wire logic [7:0] cmp_wdata,      // Compare write data.
    output logic      [7:0] buf_q,          // Buffer register, readable.
    output logic            out_ff          // Output flip-flop.
);
    logic [7:0] cnt_reg;                    // Up counter.
    logic [7:0] cmp_reg;                    // Active compare value, write-only.
    dpt_state_e state_reg;                  // Channel state.
    logic [7:0] ovf_val;                    // Overflow value for chosen period.
    logic       match;                      // Comparator output.
    logic       ovf;                        // Overflow event.
    logic       reload;                     // Counter clear event.

    // Overflow value decode; an unused period code falls back to eight bits.
    always_comb begin
        case (period_sel)
            DPT_PER_6: ovf_val = DPT_OVF_6;
            DPT_PER_7: ovf_val = DPT_OVF_7;
            default:   ovf_val = DPT_OVF_8;
        endcase
    end

    // Events fire on the tick that brings the counter onto the target, so a
    // period is the overflow value in ticks and a match there meets overflow.
    function automatic logic lands_on(input logic [7:0] cnt, input logic [7:0] tgt);
        logic [7:0] nxt;
        nxt = cnt + DPT_ONE8;
        return nxt == tgt;
    endfunction

    assign match  = lands_on(cnt_reg, cmp_reg) && tick && (state_reg != DPT_ST_IDLE);
    assign ovf    = (state_reg == DPT_ST_PWM) && tick && lands_on(cnt_reg, ovf_val);
    assign reload = (state_reg == DPT_ST_PWM) ? ovf : match;

    // State follows run and mode; both are sampled each cycle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= DPT_ST_IDLE;
        end else if (clk_en) begin
            case (state_reg)
                DPT_ST_IDLE: begin
                    if (run) begin
                        state_reg <= mode_tmr ? DPT_ST_TMR : DPT_ST_PWM;
                    end
                end
                DPT_ST_PWM, DPT_ST_TMR: begin
                    if (!run) begin
                        state_reg <= DPT_ST_IDLE;
                    end else begin
                        state_reg <= mode_tmr ? DPT_ST_TMR : DPT_ST_PWM;
                    end
                end
                default: state_reg <= DPT_ST_IDLE;
            endcase
        end
    end

    // Up counter: cleared while stopped, wraps on the clearing event.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_reg <= DPT_ZERO8;
        end else if (clk_en) begin
            if (!run) begin
                cnt_reg <= DPT_ZERO8;
            end else if (reload) begin
                cnt_reg <= DPT_ZERO8;
            end else if (tick && state_reg != DPT_ST_IDLE) begin
                cnt_reg <= cnt_reg + DPT_ONE8;
            end
        end
    end

    // Buffer and compare pair; a bus write in the same cycle as a transfer
    // wins on the buffer side, while the compare takes the old buffer.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            buf_q   <= DPT_ZERO8;
            cmp_reg <= DPT_ZERO8;
        end else if (clk_en) begin
            if (cmp_we) begin
                buf_q <= cmp_wdata;
            end
            if (cmp_we && !db_en) begin
                cmp_reg <= cmp_wdata;
            end else if (db_en && reload) begin
                cmp_reg <= buf_q;
            end
        end
    end

    // Output flip-flop; overflow is tested first so it wins over match.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_ff <= 1'b0;
        end else if (clk_en) begin
            if (ff_cmd_we && ff_cmd == DPT_CMD_SET) begin
                out_ff <= 1'b1;
            end else if (ff_cmd_we && ff_cmd == DPT_CMD_CLR) begin
                out_ff <= 1'b0;
            end else if (state_reg == DPT_ST_PWM) begin
                if (ovf) begin
                    case (ff_trg)
                        DPT_TRG_CLRM: out_ff <= 1'b1;
                        DPT_TRG_SETM: out_ff <= 1'b0;
                        DPT_TRG_INV:  out_ff <= ~out_ff;
                        default:      out_ff <= out_ff;
                    endcase
                end else if (match) begin
                    case (ff_trg)
                        DPT_TRG_CLRM: out_ff <= 1'b0;
                        DPT_TRG_SETM: out_ff <= 1'b1;
                        DPT_TRG_INV:  out_ff <= ~out_ff;
                        default:      out_ff <= out_ff;
                    endcase
                end
            end else if (state_reg == DPT_ST_TMR && match && ff_trg != DPT_TRG_OFF) begin
                out_ff <= ~out_ff;
            end
        end
    end
endmodule // dpt_channel

// ===== hw/dpt_top.sv
// Dual 8-bit PWM and interval timer with shared prescaler and register port.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module dpt_top
    import dpt_pkg::*;
(
    input  wire logic                  mclk,        // System clock, 200 MHz.
    input  wire logic                  rst_n,       // Synchronous reset, active low.
    input  wire logic                  clk_en,      // Freezes all state when low.
    input  wire logic                  gear_tick,   // Geared fast clock pulse, same domain.
    input  wire logic                  slow_clk,    // Low-frequency oscillator, asynchronous level.
    input  wire logic                  fast_tick,   // Fast oscillator pulse, same domain.
    input  wire logic [dpt_pkg::DPT_AW-1:0] addr,   // Register address.
    input  wire logic [dpt_pkg::DPT_DW-1:0] wdata,  // Write data.
    input  wire logic                  wr,          // Write strobe.
    input  wire logic                  rd,          // Read strobe.
    output logic      [dpt_pkg::DPT_DW-1:0] rdata,  // Read data, one cycle later.
    output logic                       pwm0_output_pin, // Channel 0 output.
    output logic                       pwm1_output_pin  // Channel 1 output.
);
    import dpt_pkg::*;

    logic [7:0]         run_reg;                // Timer run control.
    logic [7:0]         mod_reg [DPT_NCH];      // Per-channel mode registers.
    logic [7:0]         ffc_reg;                // Flip-flop trigger modes.
    logic [1:0]         src_reg;                // Prescaler source select.
    logic [2:0]         slow_sync;              // Slow clock synchroniser.
    logic               slow_last_reg;          // Last agreed slow clock level.
    logic [3:0]         f16_reg;                // Fast clock divide-by-16.
    logic               half_reg;               // Divide-by-2 stage.
    logic [DPT_PSW-1:0] ps_reg;                 // Prescaler.
    logic [DPT_PSW-1:0] ps_next;                // Prescaler next value.
    logic               src_tick;               // Selected source pulse.
    logic               ps_step;                // Prescaler advance pulse.
    logic [7:0]         buf_q   [DPT_NCH];      // Buffer readback.
    logic               ch_out  [DPT_NCH];      // Channel flip-flops.
    logic               ch_tick [DPT_NCH];      // Channel count ticks.
    logic               cmp_we  [DPT_NCH];      // Compare write strobes.
    logic               run_bit [DPT_NCH];      // Channel run bits.

    // Tap pulse: a tap fires when its bit and all below carry at this step.
    function automatic logic tap_fire(input logic [DPT_PSW-1:0] ps, input logic step, input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        case (sel)
            DPT_CLK_DIV4:  hit = &ps[DPT_TAP4_BIT:0];
            DPT_CLK_DIV16: hit = &ps[DPT_TAP16_BIT:0];
            DPT_CLK_DIV64: hit = &ps[DPT_TAP64_BIT:0];
            default:       hit = 1'b0;
        endcase
        return hit && step;
    endfunction

    // Slow oscillator passes three flip-flops; edges count on agreement.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slow_sync     <= 3'h0;
            slow_last_reg <= 1'b0;
        end else if (clk_en) begin
            slow_sync <= {slow_sync[1:0], slow_clk};
            if (slow_sync[1] == slow_sync[2]) begin
                slow_last_reg <= slow_sync[2];
            end
        end
    end

    // Fast oscillator divided by 16.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            f16_reg <= 4'h0;
        end else if (clk_en && fast_tick) begin
            f16_reg <= f16_reg + 4'h1;
        end
    end

    // Source select; the reserved code gives no source.
    always_comb begin
        case (src_reg)
            DPT_SRC_GEAR:   src_tick = gear_tick;
            DPT_SRC_SLOW:   src_tick = (slow_sync[1] == slow_sync[2]) && slow_sync[2] && !slow_last_reg;
            DPT_SRC_FAST16: src_tick = fast_tick && (&f16_reg);
            default:        src_tick = 1'b0;
        endcase
    end

    // Source divided by two feeds the prescaler; both stop when not running.
    assign ps_step = src_tick && half_reg;
    assign ps_next = ps_reg + {{(DPT_PSW-1){1'b0}}, 1'b1};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            half_reg <= 1'b0;
            ps_reg   <= '0;
        end else if (clk_en) begin
            if (!run_reg[DPT_RUN_PRE]) begin
                half_reg <= 1'b0;
                ps_reg   <= '0;
            end else begin
                if (src_tick) begin
                    half_reg <= ~half_reg;
                end
                if (ps_step) begin
                    ps_reg <= ps_next;
                end
            end
        end
    end

    // Control registers; writes are single-cycle and never stall.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            run_reg    <= DPT_ZERO8;
            mod_reg[0] <= DPT_ZERO8;
            mod_reg[1] <= DPT_ZERO8;
            ffc_reg    <= DPT_ZERO8;
            src_reg    <= DPT_SRC_GEAR;
        end else if (clk_en && wr) begin
            case (addr)
                DPT_ADDR_RUN:  run_reg    <= wdata;
                DPT_ADDR_MOD0: mod_reg[0] <= wdata;
                DPT_ADDR_MOD1: mod_reg[1] <= wdata;
                DPT_ADDR_FFC:  ffc_reg    <= wdata;
                DPT_ADDR_SYS:  src_reg    <= wdata[DPT_SYS_SRC_LO +: 2];
                default:       ;
            endcase
        end
    end

    // Read port: compare address returns the buffer only.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= DPT_ZERO8;
        end else if (clk_en) begin
            if (rd) begin
                case (addr)
                    DPT_ADDR_CMP0: rdata <= buf_q[0];
                    DPT_ADDR_CMP1: rdata <= buf_q[1];
                    DPT_ADDR_RUN:  rdata <= run_reg;
                    DPT_ADDR_MOD0: rdata <= mod_reg[0];
                    DPT_ADDR_MOD1: rdata <= mod_reg[1];
                    DPT_ADDR_FFC:  rdata <= {ch_out[1], ch_out[0], 2'h0, ffc_reg[DPT_FFC_STRIDE +: 2],
                                             ffc_reg[DPT_FFC_TRG_LO +: 2]};
                    DPT_ADDR_SYS:  rdata <= {6'h00, src_reg};
                    default:       rdata <= DPT_ZERO8;
                endcase
            end else begin
                rdata <= DPT_ZERO8;
            end
        end
    end

    // Two identical channels share the prescaler.
    for (genvar i = 0; i < DPT_NCH; i++) begin : g_ch
        assign run_bit[i] = (i == 0) ? run_reg[DPT_RUN_CH0] : run_reg[DPT_RUN_CH1];
        assign ch_tick[i] = tap_fire(ps_reg, ps_step, mod_reg[i][DPT_MOD_CLK_LO +: 2]);
        assign cmp_we[i]  = wr && (addr == ((i == 0) ? DPT_ADDR_CMP0 : DPT_ADDR_CMP1));

        dpt_channel u_ch (
            .mclk       (mclk),
            .rst_n      (rst_n),
            .clk_en     (clk_en),
            .run        (run_bit[i]),
            .tick       (ch_tick[i]),
            .mode_tmr   (mod_reg[i][DPT_MOD_MODE]),
            .db_en      (mod_reg[i][DPT_MOD_DBEN]),
            .period_sel (mod_reg[i][DPT_MOD_PER_LO +: 2]),
            .ff_trg     (ffc_reg[i*DPT_FFC_STRIDE + DPT_FFC_TRG_LO +: 2]),
            .ff_cmd     (wdata[i*DPT_FFC_STRIDE + DPT_FFC_CMD_LO +: 2]),
            .ff_cmd_we  (wr && addr == DPT_ADDR_FFC),
            .cmp_we     (cmp_we[i]),
            .cmp_wdata  (wdata),
            .buf_q      (buf_q[i]),
            .out_ff     (ch_out[i])
        );
    end

    // Pins come straight from the channel flip-flops.
    assign pwm0_output_pin = ch_out[0];
    assign pwm1_output_pin = ch_out[1];
endmodule // dpt_top

// ===== testbench/dpt_checker.sv
// Checker of port relations for the dual PWM timer block.
`timescale 1ns/1ps
module dpt_checker
    import dpt_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic       gear_tick,
    input wire logic       slow_clk,
    input wire logic       fast_tick,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       pwm0_output_pin,
    input wire logic       pwm1_output_pin
);
    logic       tk;     // A write is taken at this edge.
    logic [7:0] run_q;  // Shadow of the run control byte.
    logic [7:0] ffc_q;  // Shadow of the flip-flop control byte.
    logic [7:0] sys_q;  // Shadow of the clock control byte.
    assign tk = wr && clk_en;
    // Shadows give the control state without looking inside the block.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            run_q <= 8'h00;
            ffc_q <= 8'h00;
            sys_q <= 8'h00;
        end else if (tk) begin
            if (addr == DPT_ADDR_RUN) run_q <= wdata;
            if (addr == DPT_ADDR_FFC) ffc_q <= wdata;
            if (addr == DPT_ADDR_SYS) sys_q <= wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_reset_quiet:
        assert property (disable iff (1'b0) !rst_n |=> rdata == 8'h00 && !pwm0_output_pin && !pwm1_output_pin)
        else $error("outputs not cleared by reset");
    a_rdata_idle:
        assert property (clk_en && !rd |=> rdata == 8'h00) else $error("read data not zero when idle");
    a_unmapped_zero:
        assert property (rd && clk_en && !(addr inside {8'h20, [8'h26:8'h2A], 8'h6E}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_cmp_readback:
        assert property (tk && addr == DPT_ADDR_CMP0 ##1 !wr ##1 rd && clk_en && addr == DPT_ADDR_CMP0
            |=> rdata == $past(wdata, 3)) else $error("compare readback mismatch");
    a_src_readback:
        assert property (rd && clk_en && addr == DPT_ADDR_SYS |=> rdata[1:0] == sys_q[1:0])
        else $error("source select readback mismatch");
    a_stop_quiet:
        assert property (!run_q[7] [*3] ##0 !(tk && addr == DPT_ADDR_FFC)
            |=> $stable(pwm0_output_pin) && $stable(pwm1_output_pin)) else $error("pin moved while stopped");
    a_trg_readback:
        assert property (rd && clk_en && addr == DPT_ADDR_FFC |=> rdata[5:0] == {2'b00, ffc_q[5:4], ffc_q[1:0]})
        else $error("trigger readback mismatch");
    a_cmd_set:
        assert property (tk && addr == DPT_ADDR_FFC && wdata[3:2] == DPT_CMD_SET && !run_q[7] |=> pwm0_output_pin)
        else $error("set command ignored");
    a_cmd_clear:
        assert property (tk && addr == DPT_ADDR_FFC && wdata[7:6] == DPT_CMD_CLR && !run_q[7] |=> !pwm1_output_pin)
        else $error("clear command ignored");
    c_cmp_read: cover property (rd && addr == DPT_ADDR_CMP0);
    c_pre_run: cover property (tk && addr == DPT_ADDR_RUN && wdata[7]);
    c_pin_rise: cover property ($rose(pwm1_output_pin));
endmodule // dpt_checker

// ===== testbench/testbench.sv
// Self-checking bench for the dual PWM timer block.
`timescale 1ns/1ps
module testbench;
    import dpt_pkg::*;
    logic        mclk = 1'b0;      // 200 MHz clock.
    logic        rst_n = 1'b0;     // Held low for 20 cycles.
    logic        clk_en = 1'b1;    // Dropped once to refuse a write.
    logic        gear_tick = 1'b1; // Geared source ticks every cycle.
    logic        slow_clk = 1'b0;  // Slow source, 20 cycles a period.
    logic        fast_tick = 1'b1; // Fast source ticks every cycle.
    logic [7:0]  addr = 8'h00;     // Register address.
    logic [7:0]  wdata = 8'h00;    // Register write data.
    logic        wr = 1'b0;        // Write strobe.
    logic        rd = 1'b0;        // Read strobe.
    logic        rd_d = 1'b0;      // Read strobe one edge late.
    logic [7:0]  rdata;            // Read data.
    logic        pin0;             // Channel 0 output.
    logic        pin1;             // Channel 1 output.
    logic [15:0] exp_q[$];         // Read notes, mask above value.
    logic [15:0] note;             // Oldest read note.
    logic [7:0]  c1;               // Random compare values.
    logic [7:0]  c2;
    int          t;                // Tap period in cycles.
    int          ovf;              // Overflow count.
    int          bad_count = 0;
    int          comparisons = 0;
    dpt_top i_dpt_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .gear_tick(gear_tick), .slow_clk(slow_clk),
        .fast_tick(fast_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pwm0_output_pin(pin0), .pwm1_output_pin(pin1));
    always #2.5 mclk = ~mclk;
    always #50 slow_clk = ~slow_clk;
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so look there.
    always @(posedge mclk) begin
        if (rd_d) begin
            note = exp_q.pop_front();
            chk({8'h00, rdata & note[15:8]}, {8'h00, note[7:0]});
        end
        rd_d <= rd;
    end
    // Bounded wait for a channel output to reach a level.
    task automatic edge_wt(input bit ch, input logic lvl, output int n);
        n = 0;
        while ((ch ? pin1 : pin0) !== lvl) begin
            @(posedge mclk);
            n++;
            if (n > 40000) begin
                bad_count++;
                $display("BAD %0t output edge never came", $time);
                summarize();
            end
        end
    endtask
    task automatic meas(input bit ch, input int hi, input int per);
        int a, h, l;
        edge_wt(ch, 1'b0, a);
        edge_wt(ch, 1'b1, a);
        edge_wt(ch, 1'b0, h);
        edge_wt(ch, 1'b1, l);
        chk(16'(h), 16'(hi));
        chk(16'(h + l), 16'(per));
    endtask
    // Stopping first clears counter and prescaler, so each run starts at zero.
    task automatic start(input bit ch, input logic [7:0] src, mode, cmp, ffc);
        wreg(DPT_ADDR_RUN, 8'h00);
        wreg(DPT_ADDR_SYS, src);
        wreg(ch ? DPT_ADDR_MOD1 : DPT_ADDR_MOD0, mode);
        wreg(ch ? DPT_ADDR_CMP1 : DPT_ADDR_CMP0, cmp);
        wreg(DPT_ADDR_FFC, ffc);
        wreg(DPT_ADDR_RUN, ch ? 8'h88 : 8'h84);
    endtask
    initial begin
        void'($urandom(34));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rreg(DPT_ADDR_SYS, 8'h03, 8'h00);
        rreg(8'h55, 8'hFF, 8'h00);
        wreg(DPT_ADDR_FFC, 8'h48);
        rreg(DPT_ADDR_FFC, 8'h3F, 8'h00);
        for (int k = 0; k < 4; k++) begin
            c1 = 8'($urandom);
            wreg(k[0] ? DPT_ADDR_CMP1 : DPT_ADDR_CMP0, c1);
            rreg(k[0] ? DPT_ADDR_CMP1 : DPT_ADDR_CMP0, 8'hFF, c1);
        end
        clk_en <= 1'b0;
        wreg(DPT_ADDR_CMP1, ~c1);
        clk_en <= 1'b1;
        rreg(DPT_ADDR_CMP1, 8'hFF, c1);
        $display("test registers done");
        for (int k = 1; k < 4; k++) begin
            t = 4 ** k;
            ovf = (1 << (k + 5)) - 1;
            c1 = 8'($urandom_range(ovf - 1, 1));
            start(0, 8'h00, 8'(k * 5), c1, 8'h07);
            meas(0, (ovf - c1) * t, ovf * t);
        end
        for (int s = 1; s < 3; s++) begin
            t = (s == 2) ? 64 : 80;
            start(0, 8'(s), 8'h05, 8'h20, 8'h07);
            meas(0, 31 * t, 63 * t);
        end
        $display("test pwm done");
        c1 = 8'($urandom_range(62, 8));
        c2 = 8'($urandom_range(62, 1));
        start(0, 8'h00, 8'h05, c1, 8'h07);
        wreg(DPT_ADDR_MOD0, 8'h45);
        wreg(DPT_ADDR_CMP0, c2);
        rreg(DPT_ADDR_CMP0, 8'hFF, c2);
        meas(0, (63 - c1) * 4, (63 - c1 + c2) * 4);
        meas(0, (63 - c2) * 4, 252);
        $display("test buffer done");
        for (int m = 0; m < 2; m++) begin
            start(0, 8'h00, 8'h05, 8'h3F, m ? 8'h0A : 8'h07);
            c2 = 8'h00;
            repeat (600) begin
                @(posedge mclk);
                c2 = c2 | {7'h00, pin0 ^ m[0]};
            end
            chk({8'h00, c2}, 16'h0000);
        end
        c1 = 8'($urandom_range(40, 1));
        start(1, 8'h00, 8'h21, c1, 8'h50);
        meas(1, c1 * 4, c1 * 8);
        $display("test interval done");
        summarize();
    end
endmodule // testbench
bind dpt_top dpt_checker i_dpt_checker (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .gear_tick(gear_tick),
    .slow_clk(slow_clk), .fast_tick(fast_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pwm0_output_pin(pwm0_output_pin), .pwm1_output_pin(pwm1_output_pin));
